// file: src/pio_defines.svh
// register offsets, field positions, reset values and codes of the panel i/o block
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH
`define PIO_AW            8
`define PIO_OFF_FUNC      8'h00
`define PIO_OFF_MASK      8'h04
`define PIO_OFF_INVIEW    8'h08
`define PIO_OFF_OUTVIEW   8'h0c
`define PIO_OFF_JOGSPD    8'h10
`define PIO_OFF_SELECT    8'h14
`define PIO_OFF_DISPCTL   8'h18
`define PIO_OFF_STATUS    8'h1c
`define PIO_OFF_CLEAR     8'h20
`define PIO_OFF_ENABLE    8'h24
`define PIO_CODE_FORCE    16'h0196
`define PIO_CODE_NORMAL   16'h0190
`define PIO_JOG_DEFAULT   16'h0014
`define PIO_JOG_MAX       16'h1388
`define PIO_SEL_JOG       3'h5
`define PIO_NUM_FAULT     5
`define PIO_NUM_IN        9
`define PIO_NUM_OUT       6
`define PIO_NUM_EVT       5
`define PIO_EVT_FORCE_ON  0
`define PIO_EVT_FORCE_OFF 1
`define PIO_EVT_JOG       2
`define PIO_EVT_INPUT     3
`define PIO_EVT_FAULT     4
`define PIO_DISP_HIGH     0
`define PIO_DISP_HEX      1
`define PIO_DISP_MON      2
`endif

// file: src/pio_pkg.sv
// types of the panel i/o block
package pio_pkg;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        we;
        logic        re;
    } pio_bus_t;
    typedef struct packed {
        logic [15:0] value;
        logic        hex;
        logic        high;
    } pio_disp_t;
    typedef enum logic [1:0] {
        PIO_BROWSE   = 2'b00,
        PIO_SHOW_JOG = 2'b01,
        PIO_JOGGING  = 2'b11,
        PIO_FAULT    = 2'b10
    } pio_state_t;
endpackage : pio_pkg

// file: src/pio_top.sv
// panel i/o: forced outputs, pin inspection, fault history, jog and display format
`timescale 1ns/1ps
`default_nettype none
`include "pio_defines.svh"
// Operation
// - writing code 406 to the function code register enters output forcing
// - while forcing, mask bit n drives output pin n
// - writing code 400, or power cycle, leaves forcing and restores normal outputs
// - mask is volatile; after restart no forcing and no old pattern
// - input view shows the nine input pins, one bit each, hex
// - jog speed resets to 20 r/min, up/down adjust it before jog
// - on jog item, first set shows speed, second set enters jog
// - in jog, held up runs forward, held down reverse, release stops
// - jog motion only while servo enabled
// - selecting a fault slot and pressing set shows its record
// - 32-bit monitor toggles high/low and dec/hex; parameters fixed format
module pio_top
    import pio_pkg::*;
(
    // clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_arst_n,
    // register port
    input  wire pio_bus_t                i_bus,
    output logic [31:0]                  o_rdata,
    // field pins
    input  wire logic [`PIO_NUM_IN-1:0]  i_in_pins,
    output logic [`PIO_NUM_OUT-1:0]      o_out_pins,
    // drive side
    input  wire logic [`PIO_NUM_OUT-1:0] i_normal_out,
    input  wire logic                    i_servo_on,
    input  wire logic                    i_fault_valid,
    input  wire logic [15:0]             i_fault_code,
    input  wire logic [31:0]             i_monitor,
    // panel keys, active high pins
    input  wire logic                    i_key_up,
    input  wire logic                    i_key_down,
    input  wire logic                    i_key_set,
    input  wire logic                    i_key_mode,
    // jog, display, panel state and interrupt
    output logic                         o_jog_fwd,
    output logic                         o_jog_rev,
    output logic [15:0]                  o_jog_speed,
    output pio_disp_t                    o_disp,
    output logic [1:0]                   o_panel_state,
    output logic                         o_irq
);
    logic [15:0]                 func_reg;
    logic                        force_reg;
    logic [`PIO_NUM_OUT-1:0]     mask_reg;
    logic [`PIO_NUM_IN-1:0]      in_meta_reg;
    logic [`PIO_NUM_IN-1:0]      in_sync_reg;
    logic [`PIO_NUM_IN-1:0]      in_prev_reg;
    logic [3:0]                  key_meta_reg;
    logic [3:0]                  key_sync_reg;
    logic [3:0]                  key_prev_reg;
    logic [3:0]                  key_edge;
    logic [15:0]                 jog_reg;
    logic [2:0]                  sel_reg;
    logic [2:0]                  dctl_reg;
    logic [`PIO_NUM_EVT-1:0]     stat_reg;
    logic [`PIO_NUM_EVT-1:0]     en_reg;
    logic [`PIO_NUM_EVT-1:0]     evt;
    logic [15:0]                 fault_reg [`PIO_NUM_FAULT];
    pio_state_t                  state_reg;
    logic                        wr_func;
    logic                        wr_force;
    logic                        wr_normal;

    // register port decode, used by writes; reads decode the address in a case
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // record of a selected slot; a select past the history reads zero instead of an unknown
    function automatic logic [15:0] slot_rec(input logic [2:0] s);
        slot_rec = 16'h0000;
        for (int i = 0; i < `PIO_NUM_FAULT; i++)
            if (s == 3'(i))
                slot_rec = fault_reg[i];
    endfunction : slot_rec

    assign wr_func   = i_bus.we && hit(i_bus.addr, `PIO_OFF_FUNC);
    assign wr_force  = wr_func && (i_bus.wdata[15:0] == `PIO_CODE_FORCE);
    assign wr_normal = wr_func && (i_bus.wdata[15:0] == `PIO_CODE_NORMAL);

    // pin synchronisers; only the second and third stages are looked at
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            in_meta_reg  <= '0;
            in_sync_reg  <= '0;
            in_prev_reg  <= '0;
            key_meta_reg <= '0;
            key_sync_reg <= '0;
            key_prev_reg <= '0;
        end
        else
        begin
            in_meta_reg  <= i_in_pins;
            in_sync_reg  <= in_meta_reg;
            in_prev_reg  <= in_sync_reg;
            key_meta_reg <= {i_key_mode, i_key_set, i_key_down, i_key_up};
            key_sync_reg <= key_meta_reg;
            key_prev_reg <= key_sync_reg;
        end
    end

    // press edges: 0 up, 1 down, 2 set, 3 mode
    assign key_edge = key_sync_reg & ~key_prev_reg;

    // function code and forcing flag; reset is the power cycle
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            func_reg  <= '0;
            force_reg <= 1'b0;
        end
        else if (wr_func)
        begin
            func_reg <= i_bus.wdata[15:0];
            if (wr_force)
                force_reg <= 1'b1;
            else if (wr_normal)
                force_reg <= 1'b0;
        end
    end

    // mask is plain flops, cleared at reset, never reloaded from storage
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            mask_reg <= '0;
        else if (i_bus.we && hit(i_bus.addr, `PIO_OFF_MASK))
            mask_reg <= i_bus.wdata[`PIO_NUM_OUT-1:0];
    end

    // output pins: mask only reaches them while forcing
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_out_pins <= '0;
        else if (force_reg)
            o_out_pins <= mask_reg;
        else
            o_out_pins <= i_normal_out;
    end

    // fault history, newest in slot 0
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            for (int i = 0; i < `PIO_NUM_FAULT; i++)
                fault_reg[i] <= '0;
        end
        else if (i_fault_valid)
        begin
            fault_reg[0] <= i_fault_code;
            for (int i = 1; i < `PIO_NUM_FAULT; i++)
                fault_reg[i] <= fault_reg[i-1];
        end
    end

    // selection and display control, software written
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sel_reg  <= '0;
            dctl_reg <= '0;
        end
        else if (i_bus.we)
        begin
            if (hit(i_bus.addr, `PIO_OFF_SELECT) && i_bus.wdata[2:0] <= `PIO_SEL_JOG)
                sel_reg <= i_bus.wdata[2:0];
            if (hit(i_bus.addr, `PIO_OFF_DISPCTL))
                dctl_reg <= i_bus.wdata[2:0];
        end
    end

    // panel state machine; mode key always returns to browsing
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            state_reg <= PIO_BROWSE;
        else if (key_edge[3])
            state_reg <= PIO_BROWSE;
        else
        begin
            unique case (state_reg)
                PIO_BROWSE:
                    if (key_edge[2])
                        state_reg <= (sel_reg == `PIO_SEL_JOG) ? PIO_SHOW_JOG : PIO_FAULT;
                PIO_SHOW_JOG:
                    if (key_edge[2])
                        state_reg <= PIO_JOGGING;
                PIO_JOGGING:
                    state_reg <= PIO_JOGGING;
                PIO_FAULT:
                    state_reg <= PIO_FAULT;
            endcase
        end
    end

    // jog speed: keys adjust only while the value is shown, software any time
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            jog_reg <= `PIO_JOG_DEFAULT;
        else if (i_bus.we && hit(i_bus.addr, `PIO_OFF_JOGSPD))
            jog_reg <= (i_bus.wdata[15:0] > `PIO_JOG_MAX) ? `PIO_JOG_MAX : i_bus.wdata[15:0];
        else if (state_reg == PIO_SHOW_JOG && key_edge[0] && jog_reg < `PIO_JOG_MAX)
            jog_reg <= jog_reg + 16'h0001;
        else if (state_reg == PIO_SHOW_JOG && key_edge[1] && jog_reg != 16'h0000)
            jog_reg <= jog_reg - 16'h0001;
    end

    // jog motion follows the held key; both keys held means stop
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_jog_fwd   <= 1'b0;
            o_jog_rev   <= 1'b0;
            o_jog_speed <= '0;
        end
        else
        begin
            o_jog_fwd   <= (state_reg == PIO_JOGGING) && i_servo_on
                           && key_sync_reg[0] && !key_sync_reg[1];
            o_jog_rev   <= (state_reg == PIO_JOGGING) && i_servo_on
                           && key_sync_reg[1] && !key_sync_reg[0];
            o_jog_speed <= jog_reg;
        end
    end

    // display: monitor halves and radix switchable, parameters fixed
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_disp <= '0;
        else if (state_reg == PIO_FAULT)
            o_disp <= '{value: slot_rec(sel_reg), hex: 1'b1, high: 1'b0};
        else if (state_reg != PIO_BROWSE)
            o_disp <= '{value: jog_reg, hex: 1'b0, high: 1'b0};
        else if (dctl_reg[`PIO_DISP_MON])
            o_disp <= '{value: dctl_reg[`PIO_DISP_HIGH] ? i_monitor[31:16] : i_monitor[15:0],
                        hex: dctl_reg[`PIO_DISP_HEX], high: dctl_reg[`PIO_DISP_HIGH]};
        else
            o_disp <= '{value: 16'(in_sync_reg), hex: 1'b1, high: 1'b0};
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_panel_state <= '0;
        else
            o_panel_state <= state_reg;
    end

    // interrupt events
    assign evt[`PIO_EVT_FORCE_ON]  = wr_force && !force_reg;
    assign evt[`PIO_EVT_FORCE_OFF] = wr_normal && force_reg;
    assign evt[`PIO_EVT_JOG]       = state_reg == PIO_SHOW_JOG && key_edge[2] && !key_edge[3];
    assign evt[`PIO_EVT_INPUT]     = in_sync_reg != in_prev_reg;
    assign evt[`PIO_EVT_FAULT]     = i_fault_valid;

    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            stat_reg <= '0;
        else if (i_bus.we && hit(i_bus.addr, `PIO_OFF_CLEAR))
            stat_reg <= (stat_reg & ~i_bus.wdata[`PIO_NUM_EVT-1:0]) | evt;
        else
            stat_reg <= stat_reg | evt;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            en_reg <= '0;
        else if (i_bus.we && hit(i_bus.addr, `PIO_OFF_ENABLE))
            en_reg <= i_bus.wdata[`PIO_NUM_EVT-1:0];
    end

    // irq lags status by one cycle to keep the output a flop
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_irq <= 1'b0;
        else
            o_irq <= |(stat_reg & en_reg);
    end

    // read data one cycle after the strobe, zero otherwise and when unmapped
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_rdata <= '0;
        else if (!i_bus.re)
            o_rdata <= '0;
        else
        begin
            unique case (i_bus.addr)
                `PIO_OFF_FUNC:    o_rdata <= {15'h0000, force_reg, func_reg};
                `PIO_OFF_MASK:    o_rdata <= {26'h0, mask_reg};
                `PIO_OFF_INVIEW:  o_rdata <= {23'h0, in_sync_reg};
                `PIO_OFF_OUTVIEW: o_rdata <= {26'h0, o_out_pins};
                `PIO_OFF_JOGSPD:  o_rdata <= {16'h0000, jog_reg};
                `PIO_OFF_SELECT:  o_rdata <= {29'h0, sel_reg};
                `PIO_OFF_DISPCTL: o_rdata <= {29'h0, dctl_reg};
                `PIO_OFF_STATUS:  o_rdata <= {27'h0, stat_reg};
                `PIO_OFF_ENABLE:  o_rdata <= {27'h0, en_reg};
                default:          o_rdata <= '0;
            endcase
        end
    end

    // checks
    a_force_enter: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        wr_force |=> force_reg)
        else $error("forcing not entered on code write");
    a_force_drive: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        force_reg && $stable(mask_reg) |=> o_out_pins == $past(mask_reg))
        else $error("forced pins do not follow mask");
    a_force_leave: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        wr_normal ##1 !wr_force |=> o_out_pins == $past(i_normal_out))
        else $error("normal outputs not restored");
    a_input_view: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_bus.re && i_bus.addr == `PIO_OFF_INVIEW |=> o_rdata[8:0] == $past(in_sync_reg))
        else $error("input view wrong");
    a_output_view: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_bus.re && i_bus.addr == `PIO_OFF_OUTVIEW |=> o_rdata[5:0] == $past(o_out_pins))
        else $error("output view wrong");
    a_jog_enter: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        state_reg == PIO_SHOW_JOG && key_edge[2] && !key_edge[3] |=> state_reg == PIO_JOGGING)
        else $error("second set did not enter jog");
    a_jog_servo: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !$past(i_servo_on) |-> !o_jog_fwd && !o_jog_rev)
        else $error("jog motion without servo on");
    a_jog_release: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !key_sync_reg[0] |=> !o_jog_fwd)
        else $error("forward jog after key release");
    a_mask_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !force_reg && !wr_force ##1 !force_reg |=> o_out_pins == $past(i_normal_out))
        else $error("mask reached pins outside forcing");
    a_fault_show: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        state_reg == PIO_FAULT && sel_reg < 3'(`PIO_NUM_FAULT) |=> o_disp.value == $past(fault_reg[sel_reg]))
        else $error("fault record not shown");
    a_fault_range: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        state_reg == PIO_FAULT && sel_reg >= 3'(`PIO_NUM_FAULT) |=> o_disp.value == 16'h0000)
        else $error("select past history not shown blank");
endmodule : pio_top
`default_nettype wire

// file: tb/pio_field_model.sv
// field wiring model: input contacts that settle off the clock
`timescale 1ns/1ps
`default_nettype none
module pio_field_model
(
    // pattern the field equipment closes
    input  wire logic [8:0] i_want,
    // input pins toward the block
    output wire logic [8:0] o_in_pins
);
    // contacts settle 3 ns after a change, so edges never line up with the clock
    assign #3 o_in_pins = i_want;
endmodule : pio_field_model
`default_nettype wire

// file: tb/tb.sv
// self-checking bench of the panel i/o block
`timescale 1ns/1ps
`default_nettype none
`include "pio_defines.svh"
module tb
    import pio_pkg::*;
    ;
    logic        i_clk    = 1'b0;
    logic        i_arst_n = 1'b0;
    pio_bus_t    bus      = '0;
    logic [5:0]  normal   = 6'h2a;
    logic        servo    = 1'b0;
    logic        fvalid   = 1'b0;
    logic [15:0] fcode    = 16'h00a7;
    logic [31:0] mon      = 32'h12345678;
    logic [3:0]  keys     = 4'h0;
    logic [8:0]  want     = 9'h000;
    logic [31:0] d;
    wire  [8:0]  in_pins;
    logic [31:0] rdata;
    logic [5:0]  out_pins;
    logic        fwd;
    logic        rev;
    logic [15:0] jspd;
    pio_disp_t   disp;
    logic [1:0]  state;
    logic        irq;
    int          miscompares = 0;
    int          checked     = 0;

    // 50 MHz clock
    always #10 i_clk = ~i_clk;

    pio_field_model FIELD (.i_want(want), .o_in_pins(in_pins));

    pio_top DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_bus(bus), .o_rdata(rdata),
        .i_in_pins(in_pins), .o_out_pins(out_pins), .i_normal_out(normal), .i_servo_on(servo),
        .i_fault_valid(fvalid), .i_fault_code(fcode), .i_monitor(mon), .i_key_up(keys[0]),
        .i_key_down(keys[1]), .i_key_set(keys[2]), .i_key_mode(keys[3]), .o_jog_fwd(fwd),
        .o_jog_rev(rev), .o_jog_speed(jspd), .o_disp(disp), .o_panel_state(state), .o_irq(irq));

    task automatic give_verdict();
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // waits n edges, then moves to the falling edge where outputs are settled
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
        @(negedge i_clk);
    endtask : wt

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        bus <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
        @(posedge i_clk);
        bus <= '0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        bus <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
        @(posedge i_clk);
        bus <= '0;
        @(negedge i_clk);
        d = rdata;
    endtask : rd

    // key held well past the two-flop sync and edge detector
    task automatic hold(input int k, input logic v);
        @(posedge i_clk);
        keys <= v ? (keys | (4'h1 << k)) : (keys & ~(4'h1 << k));
        wt(6);
    endtask : hold

    task automatic press(input int k);
        hold(k, 1'b1);
        hold(k, 1'b0);
    endtask : press

    task automatic rst();
        i_arst_n <= 1'b0;
        wt(5);
        @(posedge i_clk);
        i_arst_n <= 1'b1;
        wt(2);
    endtask : rst

    task automatic t_reset();
        rd(`PIO_OFF_JOGSPD);
        chk("jog speed", d, 32'h14);
        chk("out pins", 32'(out_pins), 32'(normal));
        rd(8'h3c);
        chk("unmapped", d, 32'h0);
    endtask : t_reset

    task automatic t_force();
        wr(`PIO_OFF_ENABLE, 32'h3);
        wr(`PIO_OFF_MASK, 32'h5);
        wt(3);
        chk("out idle mask", 32'(out_pins), 32'(normal));
        wr(`PIO_OFF_FUNC, 32'h196);
        wt(3);
        chk("out mask 5", 32'(out_pins), 32'h5);
        chk("irq on", 32'(irq), 32'h1);
        rd(`PIO_OFF_FUNC);
        chk("func forcing", d, 32'h00010196);
        wr(`PIO_OFF_MASK, 32'h2);
        wt(3);
        chk("out mask 2", 32'(out_pins), 32'h2);
        rd(`PIO_OFF_OUTVIEW);
        chk("out view", d, 32'h2);
        wr(`PIO_OFF_FUNC, 32'h190);
        wt(3);
        chk("out normal", 32'(out_pins), 32'(normal));
        rd(`PIO_OFF_STATUS);
        chk("status", d & 32'h3, 32'h3);
        wr(`PIO_OFF_CLEAR, 32'h3);
        wt(3);
        chk("irq off", 32'(irq), 32'h0);
    endtask : t_force

    task automatic t_restart();
        wr(`PIO_OFF_FUNC, 32'h196);
        wt(3);
        chk("out before restart", 32'(out_pins), 32'h2);
        rst();
        wt(3);
        chk("out after restart", 32'(out_pins), 32'(normal));
        rd(`PIO_OFF_MASK);
        chk("mask after restart", d, 32'h0);
        rd(`PIO_OFF_FUNC);
        chk("func after restart", d, 32'h0);
    endtask : t_restart

    task automatic t_inview();
        @(posedge i_clk);
        want <= 9'h1e1;
        wt(6);
        rd(`PIO_OFF_INVIEW);
        chk("in view", d, 32'h1e1);
        chk("in disp", 32'(disp), 32'({16'h01e1, 1'b1, 1'b0}));
    endtask : t_inview

    task automatic t_fault();
        @(posedge i_clk);
        fvalid <= 1'b1;
        @(posedge i_clk);
        fvalid <= 1'b0;
        wr(`PIO_OFF_SELECT, 32'h0);
        press(2);
        chk("fault state", 32'(state), 32'h2);
        chk("fault disp", 32'(disp), 32'({16'h00a7, 1'b1, 1'b0}));
        wr(`PIO_OFF_SELECT, 32'h5);
        wt(3);
        chk("fault past history", 32'(disp), 32'({16'h0000, 1'b1, 1'b0}));
        press(3);
    endtask : t_fault

    task automatic t_jog();
        wr(`PIO_OFF_SELECT, 32'h5);
        press(2);
        chk("jog shown", 32'(state), 32'h1);
        chk("jog disp", 32'(disp), 32'({16'h0014, 1'b0, 1'b0}));
        press(0);
        chk("jog up", 32'(jspd), 32'h15);
        press(1);
        chk("jog down", 32'(jspd), 32'h14);
        press(2);
        chk("jogging", 32'(state), 32'h3);
        hold(0, 1'b1);
        chk("fwd servo off", 32'(fwd), 32'h0);
        @(posedge i_clk);
        servo <= 1'b1;
        wt(3);
        chk("fwd held", 32'(fwd), 32'h1);
        chk("jog speed held", 32'(jspd), 32'h14);
        hold(0, 1'b0);
        chk("fwd released", 32'(fwd), 32'h0);
        hold(1, 1'b1);
        chk("rev held", 32'(rev), 32'h1);
        hold(1, 1'b0);
        chk("rev released", 32'(rev), 32'h0);
        press(3);
        chk("browse", 32'(state), 32'h0);
    endtask : t_jog

    task automatic t_disp();
        wr(`PIO_OFF_DISPCTL, 32'h5);
        wt(3);
        chk("mon high dec", 32'(disp), 32'({16'h1234, 1'b0, 1'b1}));
        wr(`PIO_OFF_DISPCTL, 32'h6);
        wt(3);
        chk("mon low hex", 32'(disp), 32'({16'h5678, 1'b1, 1'b0}));
    endtask : t_disp

    // watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        #400000;
        miscompares++;
        give_verdict();
    end

    initial
    begin
        rst();
        t_reset();
        t_force();
        t_restart();
        t_inview();
        t_fault();
        t_jog();
        t_disp();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
